// >>> verilog/eivec_pkg.sv
// constants and types shared by the external interrupt and vector block
package eivec_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MCU_CTRL  = 8'h00;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h01;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h02;
  localparam logic [7:0] OFS_PC_MASK_L = 8'h03;
  localparam logic [7:0] OFS_PC_MASK_H = 8'h04;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_EXT        = 6;
  localparam int BIT_PC_HIGH    = 5;
  localparam int BIT_PC_LOW     = 4;
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [3:0] RST_REG4 = 4'h0;
  localparam int PC_PINS        = 12;
  localparam int PERIPH_SRCS    = 13;
  localparam int VEC_COUNT      = 17;
  // ----------------------------------------------------------------
  // vector addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_RESET   = 16'h0000;
  localparam logic [15:0] VEC_EXT     = 16'h0001;
  localparam logic [15:0] VEC_PC_LOW  = 16'h0002;
  localparam logic [15:0] VEC_PC_HIGH = 16'h0003;
  localparam logic [15:0] VEC_WDOG    = 16'h0004;
  localparam logic [15:0] VEC_LAST    = 16'h0010;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EIVEC_SENSE_LOW  = 2'b00,
    EIVEC_SENSE_ANY  = 2'b01,
    EIVEC_SENSE_FALL = 2'b10,
    EIVEC_SENSE_RISE = 2'b11
  } eivec_sense_e;
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } eivec_req_s;
endpackage

// >>> verilog/eivec_top.sv
// external pin, pin-change and vector selection logic
// Notes on behaviour
// - all resets start at address zero
// - pin, pin-change and watchdog vectors fixed
// - remaining peripheral vectors follow in order
// - pins trigger regardless of pin direction
// - masked toggle on inputs 7..0 flags group
// - masked toggle on inputs 11..8 flags group
// - only masked-in pins reach group requests
// - pin changes feed the wake output
// - low level requests while pin stays low
// - edges seen only through clocked sampling
// - low level feeds the wake output
// - short level wakes but gives no request
// - pin irq needs global and own enable
// - sense field bits 1..0, resets zero
// - pin sampled; pulses over one clock caught
// - sense codes: low, any, fall, rise
// - pin flag sets, clears, zero in level
// - group flags set, clear by handler/write
// - pin and group sources gated by own and global; peripheral sources by global only
//
// Local design decisions: the plain strobed port and the register offsets.
module eivec_top (
  // clock and reset
  input  wire logic                  core_clk_in,
  input  wire logic                  nrst_in,
  // register port
  input  wire logic [7:0]            reg_addr_in,
  input  wire logic [7:0]            reg_wdata_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  output logic      [7:0]            reg_rdata_out,
  // pins
  input  wire logic                  ext_irq_pin_in,
  input  wire logic [11:0]           pin_change_inputs_in,
  // core side
  input  wire logic                  global_irq_en_in,
  input  wire logic [12:0]           periph_irq_in,
  input  wire logic                  vec_ack_in,
  output eivec_pkg::eivec_req_s      vec_req_out,
  output logic                       wake_out
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  mcu_control_r;
  logic [2:0]  en_r;
  logic [7:0]  pin_change_mask_low_r;
  logic [3:0]  pin_change_mask_high_r;
  logic        ext_irq_flag_r;
  logic        pin_change_flag_low_r;
  logic        pin_change_flag_high_r;
  logic [7:0]  rdata_r;
  logic        wake_r;
  eivec_pkg::eivec_req_s vec_r;
  logic        ext_s1_r;
  logic        ext_s2_r;
  logic        ext_prev_r;
  logic [11:0] pc_s1_r;
  logic [11:0] pc_s2_r;
  logic [11:0] pc_prev_r;
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  eivec_pkg::eivec_sense_e sense;
  logic        level_mode;
  logic        ext_trig;
  logic [11:0] pc_hit;
  logic        pc_low_ev;
  logic        pc_high_ev;
  logic        wr_flags;
  logic        ack_ext;
  logic        ack_pcl;
  logic        ack_pch;
  logic [eivec_pkg::VEC_COUNT-1:0] pend;
  eivec_pkg::eivec_req_s vec_nxt;

  assign sense      = eivec_pkg::eivec_sense_e'(mcu_control_r[1:0]);
  assign level_mode = (sense == eivec_pkg::EIVEC_SENSE_LOW);
  assign wr_flags   = reg_wr_in && (reg_addr_in == eivec_pkg::OFS_IRQ_FLAGS);
  assign ack_ext    = vec_ack_in && vec_r.valid && (vec_r.addr == eivec_pkg::VEC_EXT);
  assign ack_pcl    = vec_ack_in && vec_r.valid && (vec_r.addr == eivec_pkg::VEC_PC_LOW);
  assign ack_pch    = vec_ack_in && vec_r.valid && (vec_r.addr == eivec_pkg::VEC_PC_HIGH);

  // ----------------------------------------------------------------
  // input sampling
  // ----------------------------------------------------------------
  // pins are read straight off the pad, so an output-driven pin still triggers
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ext_s1_r   <= 1'b1;
      ext_s2_r   <= 1'b1;
      ext_prev_r <= 1'b1;
    end
    else
    begin
      ext_s1_r   <= ext_irq_pin_in;
      ext_s2_r   <= ext_s1_r;
      ext_prev_r <= ext_s2_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < eivec_pkg::PC_PINS; gi++)
    begin : g_pc_sync
      always_ff @(posedge core_clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
        begin
          pc_s1_r[gi]   <= 1'b0;
          pc_s2_r[gi]   <= 1'b0;
          pc_prev_r[gi] <= 1'b0;
        end
        else
        begin
          pc_s1_r[gi]   <= pin_change_inputs_in[gi];
          pc_s2_r[gi]   <= pc_s1_r[gi];
          pc_prev_r[gi] <= pc_s2_r[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // trigger detection
  // ----------------------------------------------------------------
  // edges exist only as differences between clocked samples
  always_comb
  begin
    unique case (sense)
      eivec_pkg::EIVEC_SENSE_LOW:  ext_trig = 1'b0;
      eivec_pkg::EIVEC_SENSE_ANY:  ext_trig = ext_s2_r ^ ext_prev_r;
      eivec_pkg::EIVEC_SENSE_FALL: ext_trig = ext_prev_r & ~ext_s2_r;
      eivec_pkg::EIVEC_SENSE_RISE: ext_trig = ~ext_prev_r & ext_s2_r;
    endcase
  end

  assign pc_hit     = (pc_s2_r ^ pc_prev_r)
                      & {pin_change_mask_high_r, pin_change_mask_low_r};
  assign pc_low_ev  = |pc_hit[7:0];
  assign pc_high_ev = |pc_hit[11:8];

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      mcu_control_r          <= eivec_pkg::RST_REG8;
      en_r                   <= 3'h0;
      pin_change_mask_low_r  <= eivec_pkg::RST_REG8;
      pin_change_mask_high_r <= eivec_pkg::RST_REG4;
    end
    else if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        eivec_pkg::OFS_MCU_CTRL:  mcu_control_r <= reg_wdata_in;
        eivec_pkg::OFS_IRQ_MASK:
          en_r <= reg_wdata_in[eivec_pkg::BIT_EXT:eivec_pkg::BIT_PC_LOW];
        eivec_pkg::OFS_PC_MASK_L: pin_change_mask_low_r <= reg_wdata_in;
        eivec_pkg::OFS_PC_MASK_H: pin_change_mask_high_r <= reg_wdata_in[3:0];
        default:
        begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // flags: a new event beats a clear in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      ext_irq_flag_r <= 1'b0;
    else if (level_mode)
      ext_irq_flag_r <= 1'b0;
    else if (ext_trig)
      ext_irq_flag_r <= 1'b1;
    else if (ack_ext || (wr_flags && reg_wdata_in[eivec_pkg::BIT_EXT]))
      ext_irq_flag_r <= 1'b0;
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      pin_change_flag_low_r <= 1'b0;
    else if (pc_low_ev)
      pin_change_flag_low_r <= 1'b1;
    else if (ack_pcl || (wr_flags && reg_wdata_in[eivec_pkg::BIT_PC_LOW]))
      pin_change_flag_low_r <= 1'b0;
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      pin_change_flag_high_r <= 1'b0;
    else if (pc_high_ev)
      pin_change_flag_high_r <= 1'b1;
    else if (ack_pch || (wr_flags && reg_wdata_in[eivec_pkg::BIT_PC_HIGH]))
      pin_change_flag_high_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // request gating and priority
  // ----------------------------------------------------------------
  // level mode keeps no memory: a low that ends early leaves nothing pending
  assign pend[0] = 1'b0; // reset is not a requestable vector
  assign pend[1] = global_irq_en_in && en_r[2]
                   && (level_mode ? !ext_s2_r : ext_irq_flag_r);
  assign pend[2] = global_irq_en_in && en_r[0] && pin_change_flag_low_r;
  assign pend[3] = global_irq_en_in && en_r[1] && pin_change_flag_high_r;
  assign pend[eivec_pkg::VEC_COUNT-1:4] =
    {eivec_pkg::PERIPH_SRCS{global_irq_en_in}} & periph_irq_in;

  always_comb
  begin
    vec_nxt = '{valid: 1'b0, addr: eivec_pkg::VEC_RESET};
    for (int i = eivec_pkg::VEC_COUNT - 1; i > 0; i--)
    begin
      if (pend[i])
      begin
        vec_nxt.valid = 1'b1;
        vec_nxt.addr  = 16'(i);
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      vec_r <= '{valid: 1'b0, addr: eivec_pkg::VEC_RESET};
    else
      vec_r <= vec_nxt;
  end

  // registered wake hint; a clockless sleep path must sit beside this block
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      wake_r <= 1'b0;
    else
      wake_r <= (|pc_hit) || (en_r[2] && level_mode && !ext_s2_r);
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rdata_r <= eivec_pkg::RST_REG8;
    else if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        eivec_pkg::OFS_MCU_CTRL:  rdata_r <= mcu_control_r;
        eivec_pkg::OFS_IRQ_MASK:  rdata_r <= {1'b0, en_r, 4'h0};
        eivec_pkg::OFS_IRQ_FLAGS: rdata_r <= {1'b0, ext_irq_flag_r,
                                     pin_change_flag_high_r, pin_change_flag_low_r, 4'h0};
        eivec_pkg::OFS_PC_MASK_L: rdata_r <= pin_change_mask_low_r;
        eivec_pkg::OFS_PC_MASK_H: rdata_r <= {4'h0, pin_change_mask_high_r};
        default:                  rdata_r <= 8'h00;
      endcase
    end
    else
      rdata_r <= 8'h00;
  end

  assign reg_rdata_out = rdata_r;
  assign vec_req_out   = vec_r;
  assign wake_out      = wake_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_fall_flag;
    @(posedge core_clk_in) disable iff (!nrst_in)
      (sense == eivec_pkg::EIVEC_SENSE_FALL) && $fell(ext_s2_r) |=> ext_irq_flag_r;
  endproperty
  a_fall_flag: assert property (p_fall_flag) else $error("falling edge not flagged");

  property p_pulse_caught;
    @(posedge core_clk_in) disable iff (!nrst_in)
      (sense == eivec_pkg::EIVEC_SENSE_RISE) && !ext_irq_pin_in ##1 ext_irq_pin_in[*2]
      |-> ##[2:3] ext_irq_flag_r;
  endproperty
  a_pulse_caught: assert property (p_pulse_caught) else $error("wide pulse missed");

  property p_level_clear;
    @(posedge core_clk_in) disable iff (!nrst_in)
      level_mode [*2] |-> !ext_irq_flag_r;
  endproperty
  a_level_clear: assert property (p_level_clear) else $error("flag set in level mode");

  property p_level_req;
    @(posedge core_clk_in) disable iff (!nrst_in)
      level_mode && global_irq_en_in && en_r[2] && !ext_s2_r |=> vec_r.valid
      && vec_r.addr == eivec_pkg::VEC_EXT;
  endproperty
  a_level_req: assert property (p_level_req) else $error("low level not requested");

  property p_pc_low;
    @(posedge core_clk_in) disable iff (!nrst_in)
      |((pc_s2_r[7:0] ^ pc_prev_r[7:0]) & pin_change_mask_low_r) |=> pin_change_flag_low_r;
  endproperty
  a_pc_low: assert property (p_pc_low) else $error("group low change lost");

  property p_pc_high_masked;
    @(posedge core_clk_in) disable iff (!nrst_in)
      !pin_change_flag_high_r && pin_change_mask_high_r == 4'h0 |=> !pin_change_flag_high_r;
  endproperty
  a_pc_high_masked: assert property (p_pc_high_masked) else $error("masked pin flagged");

  property p_gie_off;
    @(posedge core_clk_in) disable iff (!nrst_in)
      !global_irq_en_in |=> !vec_r.valid;
  endproperty
  a_gie_off: assert property (p_gie_off) else $error("request without global enable");

  property p_prio;
    @(posedge core_clk_in) disable iff (!nrst_in)
      pend[1] && pend[2] |=> vec_r.addr == eivec_pkg::VEC_EXT;
  endproperty
  a_prio: assert property (p_prio) else $error("lower vector not first");

  property p_ack_clear;
    @(posedge core_clk_in) disable iff (!nrst_in)
      ack_pcl && !pc_low_ev |=> !pin_change_flag_low_r;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("handler did not clear flag");

  property p_wdog_vec;
    @(posedge core_clk_in) disable iff (!nrst_in)
      global_irq_en_in && periph_irq_in[0] && pend[3:1] == 3'b000
      |=> vec_r.addr == eivec_pkg::VEC_WDOG;
  endproperty
  a_wdog_vec: assert property (p_wdog_vec) else $error("watchdog vector wrong");

endmodule

// >>> tb/eivec_core_model.sv
// core-side partner: takes the shown vector after a chosen number of cycles
module eivec_core_model (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  nrst_in,
  // vector handshake
  input  wire eivec_pkg::eivec_req_s req_in,
  input  wire logic                  take_en_in,
  input  wire logic [2:0]            delay_in,
  output logic                       ack_out,
  output logic                       taken_out,
  output logic [15:0]                taken_addr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_r;
  logic [2:0] cool_r;
  // cool-down outlasts the two cycles the request needs to fall after an ack,
  // so one pending source is never taken twice
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      wait_r <= 3'h0;
      cool_r <= 3'h0;
      ack_out <= 1'b0;
      taken_out <= 1'b0;
      taken_addr_out <= 16'h0000;
    end
    else
    begin
      ack_out <= 1'b0;
      taken_out <= 1'b0;
      if (cool_r != 3'h0)
        cool_r <= cool_r - 3'h1;
      else if (req_in.valid && take_en_in)
      begin
        if (wait_r == delay_in)
        begin
          ack_out <= 1'b1;
          taken_out <= 1'b1;
          taken_addr_out <= req_in.addr;
          cool_r <= 3'h6;
          wait_r <= 3'h0;
        end
        else
          wait_r <= wait_r + 3'h1;
      end
      else
        wait_r <= 3'h0;
    end
  end
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the external interrupt and vector block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  core_clk_in = 1'b0;
  logic                  nrst_in = 1'b0;
  logic [7:0]            reg_addr_in = 8'h00;
  logic [7:0]            reg_wdata_in = 8'h00;
  logic                  reg_wr_in = 1'b0;
  logic                  reg_rd_in = 1'b0;
  logic [7:0]            reg_rdata_out;
  logic                  ext_irq_pin_in = 1'b1;
  logic [11:0]           pin_change_inputs_in = 12'h000;
  logic                  global_irq_en_in = 1'b0;
  logic [12:0]           periph_irq_in = 13'h0000;
  logic                  vec_ack_in;
  eivec_pkg::eivec_req_s vec_req_out;
  logic                  wake_out;
  logic                  take_en = 1'b1;
  logic [2:0]            delay = 3'h0;
  logic                  taken;
  logic [15:0]           taken_addr;
  logic                  rd_seen = 1'b0;
  logic                  woke = 1'b0;
  logic [7:0]            rd_q[$];
  logic [15:0]           vq[$];
  logic [31:0]           seed = 32'h789596df;
  logic [7:0]            r;
  int                    n_errors = 0;
  int                    check_count = 0;
  int                    cycles = 0;
  int                    k;

  always #12.5 core_clk_in = ~core_clk_in;

  eivec_top i_dut (.core_clk_in, .nrst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .ext_irq_pin_in, .pin_change_inputs_in,
    .global_irq_en_in, .periph_irq_in, .vec_ack_in, .vec_req_out, .wake_out);
  eivec_core_model i_core (.clk_in(core_clk_in), .nrst_in, .req_in(vec_req_out),
    .take_en_in(take_en), .delay_in(delay), .ack_out(vec_ack_in), .taken_out(taken),
    .taken_addr_out(taken_addr));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_vec(input logic [16:0] got, input logic [16:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: vector %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_in);
    rd_q.push_back(e);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
  endtask
  // waits until every noted vector was taken; a quiet gap follows separately
  task automatic drain();
    int n;
    n = 0;
    while (vq.size() != 0 && n < 300)
    begin
      @(negedge core_clk_in);
      n++;
    end
    if (n == 300)
    begin
      n_errors++;
      $display("Error at %0t: vector not taken", $time);
    end
  endtask
  task automatic gap();
    repeat (12) @(posedge core_clk_in);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // monitor: oldest note against each result, plus timeout
  // ----------------------------------------------------------------
  always @(posedge core_clk_in)
  begin
    if (rd_seen)
      chk_rd(reg_rdata_out, rd_q.pop_front());
    rd_seen <= reg_rd_in;
    if (taken)
      chk_vec({1'b1, taken_addr}, vq.size() != 0 ? {1'b1, vq.pop_front()} : 17'h0);
    if (wake_out === 1'b1)
      woke <= 1'b1;
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (5) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    for (k = 0; k < 6; k++)
      rd(8'(k), 8'h00);
    r = 8'(rnd());
    wr(eivec_pkg::OFS_MCU_CTRL, r);
    rd(eivec_pkg::OFS_MCU_CTRL, r);
    wr(8'h05, 8'hff);
    rd(8'h05, 8'h00);
    wr(eivec_pkg::OFS_IRQ_MASK, 8'hff);
    rd(eivec_pkg::OFS_IRQ_MASK, 8'h70);
    global_irq_en_in <= 1'b1;
    for (k = 0; k < 13; k++)
    begin
      delay <= 3'(rnd());
      periph_irq_in <= 13'h0001 << k;
      vq.push_back(eivec_pkg::VEC_WDOG + 16'(k));
      drain();
      @(posedge core_clk_in);
      periph_irq_in <= 13'h0000;
      gap();
    end
    // a request held back by the global enable is taken once it opens
    global_irq_en_in <= 1'b0;
    periph_irq_in <= 13'h1000;
    gap();
    global_irq_en_in <= 1'b1;
    vq.push_back(eivec_pkg::VEC_LAST);
    drain();
    @(posedge core_clk_in);
    periph_irq_in <= 13'h0000;
    gap();
    for (k = 1; k < 4; k++)
    begin
      wr(eivec_pkg::OFS_MCU_CTRL, 8'(k) | (8'(rnd()) & 8'hfc));
      vq.push_back(eivec_pkg::VEC_EXT);
      if (k == 1)
        vq.push_back(eivec_pkg::VEC_EXT);
      ext_irq_pin_in <= 1'b0;
      repeat (k == 1 ? 16 : 2) @(posedge core_clk_in);
      ext_irq_pin_in <= 1'b1;
      drain();
      gap();
    end
    wr(eivec_pkg::OFS_IRQ_MASK, 8'h30);
    ext_irq_pin_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    ext_irq_pin_in <= 1'b1;
    gap();
    rd(eivec_pkg::OFS_IRQ_FLAGS, 8'h40);
    wr(eivec_pkg::OFS_IRQ_FLAGS, 8'h40);
    rd(eivec_pkg::OFS_IRQ_FLAGS, 8'h00);
    // bit 7 stays masked: the toggle of pin 7 below must not reach the group
    r = (8'(rnd()) & 8'h3f) | 8'h40;
    wr(eivec_pkg::OFS_PC_MASK_L, r);
    rd(eivec_pkg::OFS_PC_MASK_L, r);
    wr(eivec_pkg::OFS_PC_MASK_H, (8'(rnd()) & 8'hf0) | 8'h02);
    rd(eivec_pkg::OFS_PC_MASK_H, 8'h02);
    pin_change_inputs_in <= 12'h080;
    gap();
    pin_change_inputs_in <= 12'h180;
    gap();
    vq.push_back(eivec_pkg::VEC_PC_LOW);
    pin_change_inputs_in <= 12'h1c0;
    drain();
    gap();
    vq.push_back(eivec_pkg::VEC_PC_HIGH);
    pin_change_inputs_in <= 12'h3c0;
    drain();
    gap();
    // four sources pending together come out lowest address first
    global_irq_en_in <= 1'b0;
    wr(eivec_pkg::OFS_IRQ_MASK, 8'h70);
    wr(eivec_pkg::OFS_MCU_CTRL, 8'h02);
    ext_irq_pin_in <= 1'b0;
    pin_change_inputs_in <= 12'h000;
    periph_irq_in <= 13'h0001;
    gap();
    rd(eivec_pkg::OFS_IRQ_FLAGS, 8'h70);
    vq = {eivec_pkg::VEC_EXT, eivec_pkg::VEC_PC_LOW, eivec_pkg::VEC_PC_HIGH,
      eivec_pkg::VEC_WDOG};
    global_irq_en_in <= 1'b1;
    drain();
    @(posedge core_clk_in);
    periph_irq_in <= 13'h0000;
    ext_irq_pin_in <= 1'b1;
    gap();
    take_en <= 1'b0;
    wr(eivec_pkg::OFS_MCU_CTRL, 8'h00);
    ext_irq_pin_in <= 1'b0;
    repeat (5) @(posedge core_clk_in);
    @(negedge core_clk_in);
    chk_vec(vec_req_out, {1'b1, eivec_pkg::VEC_EXT});
    rd(eivec_pkg::OFS_IRQ_FLAGS, 8'h00);
    ext_irq_pin_in <= 1'b1;
    gap();
    @(negedge core_clk_in);
    chk_vec({vec_req_out.valid, 16'h0000}, 17'h0);
    chk_vec({16'h0000, woke}, 17'h1);
    report_and_stop();
  end
endmodule
